// [core/psw_pkg.sv]
package psw_pkg;

   // ==========================================================
   // Register location and layout
   // ==========================================================
   localparam logic [7:0] PSW_ADDR = 8'hD0;
   localparam logic [7:0] PSW_RESET = 8'h00;
   localparam logic [7:0] PSW_WRITE_MASK = 8'hFE;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [2:0] CARRY_POS = 3'h7;
   localparam logic [2:0] AUX_POS = 3'h6;
   localparam logic [2:0] USER0_POS = 3'h5;
   localparam logic [2:0] BANK_HI_POS = 3'h4;
   localparam logic [2:0] BANK_LO_POS = 3'h3;
   localparam logic [2:0] OVERFLOW_POS = 3'h2;
   localparam logic [2:0] USER1_POS = 3'h1;
   localparam logic [2:0] PARITY_POS = 3'h0;

   // ==========================================================
   // Working register banks
   // ==========================================================
   localparam int BANK_COUNT = 4;
   localparam int BANK_REGS = 8;

   // ==========================================================
   // Arithmetic requests and answers
   // ==========================================================
   typedef enum logic [2:0] {
      ALU_NONE,
      ALU_ADD,
      ALU_ADDC,
      ALU_SUBB,
      ALU_MUL,
      ALU_DIV
   } alu_op_type;

   typedef struct packed {
      alu_op_type op;
      logic [7:0] a;
      logic [7:0] b;
   } alu_req_type;

   typedef struct packed {
      logic carry;
      logic aux;
      logic overflow;
      logic [7:0] low;
      logic [7:0] high;
   } alu_res_type;

endpackage : psw_pkg

// [core/program_status_word_flags.sv]
// Overview of operation
// - Carry bit 7 set on add carry or subtract borrow, other arithmetic clears it
// - Aux carry bit 6 set on nibble carry or borrow, other arithmetic clears it
// - Bits 5 and 1 are software flags, never changed by hardware
// - Bank select bits 4:3 pick register bank at 0x00, 0x08, 0x10 or 0x18
// - Overflow bit 2 set on signed overflow of add, add with carry, subtract
// - Overflow set when a multiply product exceeds 255
// - Overflow set when a divide has a zero divisor
// - Those five operations clear overflow when no overflow condition occurs
// - Read-only bit 0 shows odd parity of the accumulator
// - Status word sits at SFR address 0xD0 on every page, bit addressable
// - Each bank holds eight byte registers; only selected bank active; R0/R1 index
module program_status_word_flags
   import psw_pkg::*;
#(
   parameter int DATA_WIDTH = 8
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire alu_req_type ALU_REQ_IN,
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] SFR_ADDR_IN,
   input wire logic SFR_WR_IN,
   input wire logic [7:0] SFR_WDATA_IN,
   input wire logic SFR_RD_IN,
   input wire logic [7:0] BIT_ADDR_IN,
   input wire logic BIT_WR_IN,
   input wire logic BIT_WVAL_IN,
   input wire logic BIT_RD_IN,
   input wire logic [2:0] REG_SEL_IN,
   input wire logic REG_WR_IN,
   input wire logic [DATA_WIDTH-1:0] REG_WDATA_IN,
   input wire logic INDEX_SEL_IN,
   output logic [7:0] SFR_RDATA_OUT,
   output logic SFR_RVALID_OUT,
   output logic BIT_RDATA_OUT,
   output logic BIT_RVALID_OUT,
   output logic [DATA_WIDTH-1:0] REG_RDATA_OUT,
   output logic [DATA_WIDTH-1:0] INDEX_OUT,
   output logic [7:0] PSW_OUT,
   output logic [4:0] BANK_BASE_OUT,
   output alu_res_type ALU_RES_OUT,
   output logic ALU_DONE_OUT
);

   // ==========================================================
   // Helper functions
   // ==========================================================

   // Odd parity: one when an odd number of bits are set
   function automatic logic odd_parity(input logic [7:0] value);
      odd_parity = ^value;
   endfunction : odd_parity

   // Add or subtract with carry in, giving flags and result
   function automatic alu_res_type add_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic subtract);
      logic [8:0] full;
      logic [4:0] nib;
      alu_res_type res;
      full = 9'h000;
      nib = 5'h00;
      res = '0;
      if (subtract) begin
         full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
         res.overflow = (a[7] != b[7]) && (full[7] != a[7]);
      end else begin
         full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         res.overflow = (a[7] == b[7]) && (full[7] != a[7]);
      end
      res.carry = full[8];
      res.aux = nib[4];
      res.low = full[7:0];
      res.high = BYTE_ZERO;
      add_sub = res;
   endfunction : add_sub

   // ==========================================================
   // State
   // ==========================================================
   logic [7:0] psw;
   logic [7:0] next_psw;
   alu_res_type next_res;
   logic alu_active;
   logic byte_hit;
   logic bit_hit;
   logic [4:0] reg_addr;
   logic [4:0] index_addr;
   logic [15:0] product;
   logic [DATA_WIDTH-1:0] bank_mem [BANK_COUNT*BANK_REGS];

   // ==========================================================
   // Address decode
   // ==========================================================

   // Decode ignores the SFR page, so the word is seen on all pages
   assign byte_hit = (SFR_ADDR_IN == PSW_ADDR);
   assign bit_hit = (BIT_ADDR_IN[7:3] == PSW_ADDR[7:3]);
   assign alu_active = (ALU_REQ_IN.op != ALU_NONE);

   // Register location inside the selected bank
   assign reg_addr = {psw[BANK_HI_POS], psw[BANK_LO_POS], REG_SEL_IN};
   assign index_addr = {psw[BANK_HI_POS], psw[BANK_LO_POS], 2'h0, INDEX_SEL_IN};

   // ==========================================================
   // Arithmetic and flag results
   // ==========================================================
   assign product = {8'h00, ALU_REQ_IN.a} * {8'h00, ALU_REQ_IN.b};

   // Result and flags of the requested operation
   always_comb begin
      next_res = '0;
      case (ALU_REQ_IN.op)
         ALU_ADD: begin
            next_res = add_sub(ALU_REQ_IN.a, ALU_REQ_IN.b, 1'b0, 1'b0);
         end
         ALU_ADDC: begin
            next_res = add_sub(ALU_REQ_IN.a, ALU_REQ_IN.b, psw[CARRY_POS], 1'b0);
         end
         ALU_SUBB: begin
            next_res = add_sub(ALU_REQ_IN.a, ALU_REQ_IN.b, psw[CARRY_POS], 1'b1);
         end
         ALU_MUL: begin
            next_res.low = product[7:0];
            next_res.high = product[15:8];
            next_res.overflow = (product[15:8] != BYTE_ZERO);
         end
         ALU_DIV: begin
            if (ALU_REQ_IN.b == BYTE_ZERO) begin
               next_res.overflow = 1'b1;
               next_res.low = BYTE_MAX;
               next_res.high = BYTE_MAX;
            end else begin
               next_res.low = ALU_REQ_IN.a / ALU_REQ_IN.b;
               next_res.high = ALU_REQ_IN.a % ALU_REQ_IN.b;
            end
         end
         default: begin
            next_res = '0;
         end
      endcase
   end

   // ==========================================================
   // Status word next value
   // ==========================================================

   // Flag update, then bit write, then byte write, parity last
   always_comb begin
      next_psw = psw;
      if (alu_active) begin
         next_psw[CARRY_POS] = next_res.carry;
         next_psw[AUX_POS] = next_res.aux;
         next_psw[OVERFLOW_POS] = next_res.overflow;
      end
      if (BIT_WR_IN && bit_hit && (BIT_ADDR_IN[2:0] != PARITY_POS)) begin
         next_psw[BIT_ADDR_IN[2:0]] = BIT_WVAL_IN;
      end
      if (SFR_WR_IN && byte_hit) begin
         next_psw = SFR_WDATA_IN & PSW_WRITE_MASK;
      end
      next_psw[PARITY_POS] = odd_parity(ACC_IN);
   end

   // Status word register; user flags change only by writes
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         psw <= PSW_RESET;
      end else begin
         psw <= next_psw;
      end
   end

   // ==========================================================
   // Outputs of the status word
   // ==========================================================

   // Copy of the word and the active bank base address
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         PSW_OUT <= PSW_RESET;
         BANK_BASE_OUT <= 5'h00;
      end else begin
         PSW_OUT <= next_psw;
         BANK_BASE_OUT <= {next_psw[BANK_HI_POS], next_psw[BANK_LO_POS], 3'h0};
      end
   end

   // Byte read shows live accumulator parity in bit 0
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         SFR_RDATA_OUT <= BYTE_ZERO;
         SFR_RVALID_OUT <= 1'b0;
      end else begin
         SFR_RVALID_OUT <= SFR_RD_IN && byte_hit;
         if (SFR_RD_IN && byte_hit) begin
            SFR_RDATA_OUT <= {psw[7:1], odd_parity(ACC_IN)};
         end else begin
            SFR_RDATA_OUT <= BYTE_ZERO;
         end
      end
   end

   // Single bit read of the word
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         BIT_RDATA_OUT <= 1'b0;
         BIT_RVALID_OUT <= 1'b0;
      end else begin
         BIT_RVALID_OUT <= BIT_RD_IN && bit_hit;
         if (BIT_RD_IN && bit_hit) begin
            if (BIT_ADDR_IN[2:0] == PARITY_POS) begin
               BIT_RDATA_OUT <= odd_parity(ACC_IN);
            end else begin
               BIT_RDATA_OUT <= psw[BIT_ADDR_IN[2:0]];
            end
         end else begin
            BIT_RDATA_OUT <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Arithmetic result outputs
   // ==========================================================

   // Result registered, done pulses one cycle after the request
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ALU_RES_OUT <= '0;
         ALU_DONE_OUT <= 1'b0;
      end else begin
         ALU_DONE_OUT <= alu_active;
         if (alu_active) begin
            ALU_RES_OUT <= next_res;
         end
      end
   end

   // ==========================================================
   // Working register banks
   // ==========================================================

   // Write into the selected bank only
   always_ff @(posedge CLK_IN) begin
      if (REG_WR_IN) begin
         bank_mem[reg_addr] <= REG_WDATA_IN;
      end
   end

   // Register read and index register read from the selected bank
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= '0;
         INDEX_OUT <= '0;
      end else begin
         REG_RDATA_OUT <= bank_mem[reg_addr];
         INDEX_OUT <= bank_mem[index_addr];
      end
   end

endmodule : program_status_word_flags

// [testbench/psw_asserts.sv]
module psw_asserts
   import psw_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire alu_req_type ALU_REQ_IN,
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] SFR_ADDR_IN,
   input wire logic SFR_WR_IN,
   input wire logic [7:0] SFR_WDATA_IN,
   input wire logic SFR_RD_IN,
   input wire logic BIT_WR_IN,
   input wire logic [7:0] SFR_RDATA_OUT,
   input wire logic SFR_RVALID_OUT,
   input wire logic [7:0] PSW_OUT,
   input wire logic [4:0] BANK_BASE_OUT,
   input wire alu_res_type ALU_RES_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // ========
   // Helpers
   logic [8:0] sum;
   logic add_ov;
   logic [15:0] prod;
   logic wr_hit;
   logic rd_hit;
   logic quiet;
   // Reference arithmetic and decodes from the request
   assign sum = {1'b0, ALU_REQ_IN.a} + {1'b0, ALU_REQ_IN.b};
   assign add_ov = (ALU_REQ_IN.a[7] == ALU_REQ_IN.b[7]) && (sum[7] != ALU_REQ_IN.a[7]);
   assign prod = {8'h00, ALU_REQ_IN.a} * {8'h00, ALU_REQ_IN.b};
   assign wr_hit = SFR_WR_IN && SFR_ADDR_IN == PSW_ADDR;
   assign rd_hit = SFR_RD_IN && SFR_ADDR_IN == PSW_ADDR;
   assign quiet = !wr_hit && !BIT_WR_IN;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // ========
   // Properties
   a_parity_tracks: assert property (
      $past(RST_N_IN) |-> PSW_OUT[0] == ^$past(ACC_IN)) else $error("parity bit wrong");
   a_add_carry: assert property (
      ALU_REQ_IN.op == ALU_ADD && quiet |=> PSW_OUT[7] == $past(sum[8]))
      else $error("add carry wrong");
   a_mul_overflow: assert property (
      ALU_REQ_IN.op == ALU_MUL && quiet |=> PSW_OUT[2] == ($past(prod) > 16'h00FF) && !PSW_OUT[7])
      else $error("multiply flags wrong");
   a_div_zero: assert property (
      ALU_REQ_IN.op == ALU_DIV && ALU_REQ_IN.b == BYTE_ZERO && quiet
      |=> ALU_RES_OUT.overflow && PSW_OUT[2] && ALU_RES_OUT.low == BYTE_MAX)
      else $error("divide zero");
   a_user_hold: assert property (
      quiet |=> $stable(PSW_OUT[5]) && $stable(PSW_OUT[1])) else $error("user flag changed");
   a_bank_base: assert property (
      BANK_BASE_OUT == {PSW_OUT[4:3], 3'h0}) else $error("bank base wrong");
   a_write_wins: assert property (
      wr_hit |=> PSW_OUT[7:1] == $past(SFR_WDATA_IN[7:1])) else $error("byte write lost");
   a_read_reply: assert property (
      rd_hit && !wr_hit |=> SFR_RVALID_OUT && SFR_RDATA_OUT == {$past(PSW_OUT[7:1]), ^$past(ACC_IN)})
      else $error("read reply wrong");
   a_stray_valid: assert property (
      !rd_hit |=> !SFR_RVALID_OUT) else $error("valid without read");
   a_add_overflow: assert property (
      ALU_REQ_IN.op == ALU_ADD && quiet |=> PSW_OUT[2] == $past(add_ov))
      else $error("add overflow wrong");
   a_bank_write: assert property (
      wr_hit |=> BANK_BASE_OUT == {$past(SFR_WDATA_IN[4:3]), 3'h0})
      else $error("bank base not written");
endmodule : psw_asserts

bind program_status_word_flags psw_asserts chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .ALU_REQ_IN(ALU_REQ_IN), .ACC_IN(ACC_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WR_IN(SFR_WR_IN),
   .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_RD_IN(SFR_RD_IN), .BIT_WR_IN(BIT_WR_IN),
   .SFR_RDATA_OUT(SFR_RDATA_OUT), .SFR_RVALID_OUT(SFR_RVALID_OUT), .PSW_OUT(PSW_OUT),
   .BANK_BASE_OUT(BANK_BASE_OUT), .ALU_RES_OUT(ALU_RES_OUT));

// [testbench/exec_model.sv]
module exec_model
   import psw_pkg::*;
(
   input wire logic clk_in,
   output alu_req_type req_out,
   output logic [7:0] acc_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle request and cleared accumulator at start
   initial begin
      req_out = '{ALU_NONE, 8'h00, 8'h00};
      acc_out = 8'h00;
   end
   // One-cycle request; operands scrambled once released
   task automatic issue(input alu_op_type op, input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_in) #2 req_out = '{op, a, b};
      @(posedge clk_in) #2 req_out = '{ALU_NONE, ~a, ~b};
   endtask : issue
   // New accumulator value just after an edge
   task automatic load_acc(input logic [7:0] v);
      @(posedge clk_in) #2 acc_out = v;
   endtask : load_acc
endmodule : exec_model

// [testbench/testbench.sv]
module testbench
   import psw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, bwr = 1'b0, bval = 1'b0, brd = 1'b0;
   logic rwr = 1'b0, isel = 1'b0, rvalid, brdata, bvalid, done;
   logic [7:0] addr = 8'h00, wdata = 8'h00, baddr = 8'h00, rwd = 8'h00, rdata, regq, idx, psw;
   logic [7:0] acc;
   logic [2:0] rsel = 3'h0;
   logic [4:0] base;
   alu_res_type res;
   alu_req_type req;
   int n_mismatch = 0;
   int checks = 0;
   logic [21:0] tab [8] = '{{ALU_ADD, 8'h80, 8'h80, 3'h5}, {ALU_ADDC, 8'h0F, 8'h00, 3'h2},
      {ALU_SUBB, 8'h00, 8'h01, 3'h6}, {ALU_SUBB, 8'h80, 8'h00, 3'h3},
      {ALU_MUL, 8'h10, 8'h10, 3'h1}, {ALU_MUL, 8'h02, 8'h03, 3'h0},
      {ALU_DIV, 8'h05, 8'h00, 3'h1}, {ALU_DIV, 8'h09, 8'h02, 3'h0}};
   exec_model part (.clk_in(clk), .req_out(req), .acc_out(acc));
   program_status_word_flags dut (
      .CLK_IN(clk), .RST_N_IN(rst_n), .ALU_REQ_IN(req), .ACC_IN(acc),
      .SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RD_IN(rd),
      .BIT_ADDR_IN(baddr), .BIT_WR_IN(bwr), .BIT_WVAL_IN(bval), .BIT_RD_IN(brd),
      .REG_SEL_IN(rsel), .REG_WR_IN(rwr), .REG_WDATA_IN(rwd), .INDEX_SEL_IN(isel),
      .SFR_RDATA_OUT(rdata), .SFR_RVALID_OUT(rvalid), .BIT_RDATA_OUT(brdata),
      .BIT_RVALID_OUT(bvalid), .REG_RDATA_OUT(regq), .INDEX_OUT(idx), .PSW_OUT(psw),
      .BANK_BASE_OUT(base), .ALU_RES_OUT(res), .ALU_DONE_OUT(done));
   // ========
   // Access tasks
   // Free-running 50 ns clock
   always #25 clk = ~clk;
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Byte write strobe for one cycle
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #2 {addr, wdata, wr} = {a, d, 1'b1};
      @(posedge clk) #2 wr = 1'b0;
   endtask : sfr_wr
   // Byte read; reply stands in the following cycle
   task automatic sfr_rd(input logic [7:0] a, input logic v, input logic [7:0] e);
      @(posedge clk) #2 {addr, rd} = {a, 1'b1};
      @(posedge clk) #2 rd = 1'b0;
      chk("read valid", {7'h00, v}, {7'h00, rvalid});
      if (v) chk("read data", e, rdata);
   endtask : sfr_rd
   // Bit write when w is set, bit read otherwise
   task automatic bit_acc(input logic [7:0] a, input logic w, input logic v);
      @(posedge clk) #2 {baddr, bwr, brd, bval} = {a, w, !w, v};
      @(posedge clk) #2 {bwr, brd} = 2'h0;
   endtask : bit_acc
   // Counts and verdict
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // ========
   // Main sequence
   initial begin
      int i;
      int b;
      logic [21:0] e;
      repeat (2) @(posedge clk);
      #2 rst_n = 1'b1;
      chk("reset word", PSW_RESET, psw);
      sfr_wr(PSW_ADDR, BYTE_MAX);
      sfr_rd(PSW_ADDR, 1'b1, 8'hFE);
      sfr_rd(8'hD1, 1'b0, 8'h00);
      for (b = 0; b < 4; b++) begin
         sfr_wr(PSW_ADDR, 8'(b << 3));
         chk("bank base", 8'(b << 3), {3'h0, base});
         @(posedge clk) #2 {rsel, rwd, rwr} = {3'h0, 8'(8'hA0 + b), 1'b1};
         @(posedge clk) #2 rwr = 1'b0;
      end
      for (b = 0; b < 4; b++) begin
         sfr_wr(PSW_ADDR, 8'(b << 3));
         @(posedge clk) #2;
         chk("bank reg", 8'(8'hA0 + b), regq);
         chk("index reg", 8'(8'hA0 + b), idx);
      end
      // Second index register R1 of the last selected bank
      @(posedge clk) #2 {rsel, rwd, rwr, isel} = {3'h1, 8'h5C, 1'b1, 1'b1};
      @(posedge clk) #2 rwr = 1'b0;
      @(posedge clk) #2;
      chk("bank reg r1", 8'h5C, regq);
      chk("index reg r1", 8'h5C, idx);
      sfr_wr(PSW_ADDR, 8'h22);
      for (i = 0; i < 8; i++) begin
         e = tab[i];
         part.issue(alu_op_type'(e[21:19]), e[18:11], e[10:3]);
         for (b = 0; b < 4 && done !== 1'b1; b++) begin
            @(posedge clk) #2;
         end
         if (done !== 1'b1) begin
            chk("alu done", 8'h01, {7'h00, done});
            close_out();
         end
         chk("alu flags", {e[2:1], 3'h4, e[0], 2'h2}, psw);
         chk("res flags", {5'h00, e[2:0]}, {5'h00, res.carry, res.aux, res.overflow});
      end
      chk("divide quotient", 8'h04, res.low);
      chk("divide remainder", 8'h01, res.high);
      fork
         part.issue(ALU_ADD, 8'h80, 8'h80);
         sfr_wr(PSW_ADDR, 8'h00);
      join
      chk("write priority", 8'h00, psw);
      part.load_acc(8'h07);
      bit_acc(8'hD5, 1'b1, 1'b1);
      chk("parity and flag", 8'h21, psw);
      bit_acc(8'hD0, 1'b0, 1'b0);
      chk("bit read", 8'h03, {6'h00, bvalid, brdata});
      close_out();
   end
endmodule : testbench
